// *** ftr_host_model.sv ***
module ftr_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h60
)
(
   // clock
   input wire logic clock_i,
   // serial pins, sda_i is the resolved wire
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] dev = DEV_ADDR;
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // two quarters make a 6 clock scl half period, above the 4 clock floor
   task automatic qp();
      repeat (3) @(negedge clock_i);
   endtask
   task automatic start();
      qp();
      sda_o = 1'b1;
      qp();
      scl_o = 1'b1;
      qp();
      sda_o = 1'b0;
      qp();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      qp();
      sda_o = 1'b0;
      qp();
      scl_o = 1'b1;
      qp();
      sda_o = 1'b1;
      qp();
   endtask
   task automatic bit_io(input logic b, output logic s);
      qp();
      sda_o = b;
      qp();
      scl_o = 1'b1;
      qp();
      s = sda_i;
      qp();
      scl_o = 1'b0;
   endtask
   // master always releases the ninth bit: slave ack on writes, nack on reads
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
      output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(1'b1, k);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n,
      output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start();
      xfer({dev, 1'b0}, q, k0);
      xfer(a, q, k1);
      xfer(d, q, k2);
      for (int i = 1; i < n; i++)
         xfer(~d, q, k2);
      stop();
      ok = !(k0 | k1 | k2);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start();
      xfer({dev, 1'b0}, q, k0);
      xfer(a, q, k1);
      start();
      xfer({dev, 1'b1}, q, k2);
      xfer(8'hFF, d, k3);
      stop();
      ok = !(k0 | k1 | k2) && k3;
   endtask
endmodule

// *** ftr_pkg.sv ***
package ftr_pkg;
   // register offsets
   localparam logic [7:0] FTR_ADR_RADIO_CONTROL = 8'h0F;
   localparam logic [7:0] FTR_ADR_TUNE_POS_LOW = 8'h10;
   localparam logic [7:0] FTR_ADR_TUNE_POS_HIGH_STATUS = 8'h11;
   localparam logic [7:0] FTR_ADR_REF_CLOCK_PRESCALE = 8'h19;
   localparam logic [7:0] FTR_ADR_REF_CLOCK_DIVIDER = 8'h1A;
   localparam logic [7:0] FTR_ADR_REF_CLOCK_OFFSET = 8'h1B;
   localparam logic [7:0] FTR_ADR_SEARCH_CONTROL = 8'h1D;
   localparam logic [7:0] FTR_ADR_TARGET_LOW = 8'h1E;
   localparam logic [7:0] FTR_ADR_TARGET_HIGH = 8'h1F;
   // reset values
   localparam logic [7:0] FTR_RST_RADIO_CONTROL = 8'h00;
   localparam logic [7:0] FTR_RST_PRESCALE = 8'h00;
   localparam logic [7:0] FTR_RST_DIVIDER = 8'h00;
   localparam logic [7:0] FTR_RST_OFFSET = 8'h00;
   localparam logic [7:0] FTR_RST_SEARCH = 8'h00;
   localparam logic [7:0] FTR_RST_TARGET = 8'h00;
   // radio control fields
   localparam int FTR_POWER_BIT = 0;
   localparam int FTR_SRC_LSB = 1;
   localparam int FTR_DONE_IE_BIT = 6;
   localparam int FTR_IRQ_POLARITY_BIT = 7;
   localparam logic [1:0] FTR_SRC_OFF = 2'h0;
   localparam logic [1:0] FTR_SRC_FORBIDDEN = 2'h1;
   localparam logic [1:0] FTR_SRC_OSC_DIV = 2'h2;
   localparam logic [1:0] FTR_SRC_DIRECT = 2'h3;
   localparam int FTR_OSC_DIV = 32;
   // status fields
   localparam int FTR_ERR_LSB = 5;
   localparam int FTR_DONE_BIT = 4;
   localparam int FTR_FLAG_A_BIT = 3;
   // prescale and search fields
   localparam int FTR_PRE_LSB = 5;
   localparam int FTR_SLOPE_LSB = 0;
   localparam int FTR_GRID_LSB = 6;
   localparam int FTR_LOCK_BIT = 5;
   localparam int FTR_THR_LSB = 1;
   localparam int FTR_PLUS5_BIT = 0;
   localparam int FTR_SEARCH_SEL_BIT = 7;
   // error codes
   localparam logic [2:0] FTR_ERR_OK = 3'h0;
   localparam logic [2:0] FTR_ERR_RESET = 3'h1;
   localparam logic [2:0] FTR_ERR_BAND = 3'h2;
   localparam logic [2:0] FTR_ERR_DAC = 3'h3;
   localparam logic [2:0] FTR_ERR_FORCED = 3'h6;
   localparam logic [2:0] FTR_ERR_BUSY = 3'h7;
   // serial device address, write form C0h
   localparam logic [6:0] FTR_DEV_ADDR = 7'h60;

   typedef enum logic [2:0] {
      FTR_CMD_IDLE = 3'b001,
      FTR_CMD_TUNE = 3'b010,
      FTR_CMD_SEARCH = 3'b100
   } ftr_cmd_t;

   typedef enum logic [4:0] {
      FTR_SER_IDLE = 5'b00001,
      FTR_SER_DEV = 5'b00010,
      FTR_SER_REG = 5'b00100,
      FTR_SER_WR = 5'b01000,
      FTR_SER_RD = 5'b10000
   } ftr_ser_t;
endpackage

// *** ftr_serial_slave.sv ***
module ftr_serial_slave
   import ftr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = ftr_pkg::FTR_DEV_ADDR
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_n_o,
   // register side
   output logic wr_stb_o,
   output logic rd_stb_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   ftr_ser_t state_r;
   logic scl_q, sda_q, first_r, ack_ph_r, nack_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r, tx_r;
   logic scl_rise, scl_fall, start_c, stop_c;

   assign scl_rise = scl_i && !scl_q;
   assign scl_fall = !scl_i && scl_q;
   assign start_c = scl_i && scl_q && sda_q && !sda_i;
   assign stop_c = scl_i && scl_q && !sda_q && sda_i;

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   always_ff @(posedge clock_i)
   begin
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
      if (rst_i)
      begin
         state_r <= FTR_SER_IDLE;
         cnt_r <= 4'h0;
         ack_ph_r <= 1'b0;
         first_r <= 1'b0;
         nack_r <= 1'b0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         addr_o <= 8'h00;
         wdata_o <= 8'h00;
         sda_oe_n_o <= 1'b1;
      end
      else if (start_c)
      begin
         state_r <= FTR_SER_DEV;
         cnt_r <= 4'h0;
         ack_ph_r <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end
      else if (stop_c)
      begin
         state_r <= FTR_SER_IDLE;
         sda_oe_n_o <= 1'b1;
      end
      else if (state_r != FTR_SER_IDLE && scl_rise)
      begin
         if (cnt_r < 4'h8)
         begin
            shift_r <= {shift_r[6:0], sda_i};
            cnt_r <= cnt_r + 4'h1;
         end
         else
            nack_r <= sda_i;
      end
      else if (state_r != FTR_SER_IDLE && scl_fall)
      begin
         if (cnt_r == 4'h8 && !ack_ph_r)
         begin
            // byte complete: acknowledge or hand the bus to the master
            ack_ph_r <= 1'b1;
            sda_oe_n_o <= 1'b0;
            case (state_r)
               FTR_SER_DEV:
                  if (shift_r[7:1] != DEV_ADDR)
                  begin
                     sda_oe_n_o <= 1'b1;
                     state_r <= FTR_SER_IDLE;
                  end
               FTR_SER_REG:
                  addr_o <= shift_r;
               FTR_SER_WR:
               begin
                  // only the first data byte lands
                  if (first_r)
                  begin
                     wdata_o <= shift_r;
                     wr_stb_o <= 1'b1;
                  end
                  first_r <= 1'b0;
               end
               FTR_SER_RD:
                  sda_oe_n_o <= 1'b1;
               default:
                  sda_oe_n_o <= 1'b1;
            endcase
         end
         else if (cnt_r == 4'h8)
         begin
            ack_ph_r <= 1'b0;
            cnt_r <= 4'h0;
            sda_oe_n_o <= 1'b1;
            case (state_r)
               FTR_SER_DEV:
                  if (shift_r[0])
                  begin
                     state_r <= FTR_SER_RD;
                     tx_r <= rdata_i;
                     rd_stb_o <= 1'b1;
                     sda_oe_n_o <= rdata_i[7];
                  end
                  else
                     state_r <= FTR_SER_REG;
               FTR_SER_REG:
               begin
                  state_r <= FTR_SER_WR;
                  first_r <= 1'b1;
               end
               FTR_SER_RD:
                  if (nack_r)
                     state_r <= FTR_SER_IDLE;
                  else
                  begin
                     tx_r <= rdata_i;
                     rd_stb_o <= 1'b1;
                     sda_oe_n_o <= rdata_i[7];
                  end
               FTR_SER_WR:
                  state_r <= FTR_SER_WR;
               default:
                  state_r <= FTR_SER_IDLE;
            endcase
         end
         else if (state_r == FTR_SER_RD)
         begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_n_o <= tx_r[6];
         end
      end
   end
endmodule

// *** ftr_tuning_regs.sv ***
module ftr_tuning_regs
   import ftr_pkg::*;
#(
   parameter int POS_W = 10,
   parameter logic [6:0] DEV_ADDR = ftr_pkg::FTR_DEV_ADDR
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // interrupt pin
   output logic irq_o,
   output logic irq_oe_n_o,
   // field strength from the receiver
   input wire logic [2:0] strength_i,
   input wire logic strength_plus5_i,
   // controls towards the receiver
   output logic radio_power_on_o,
   output logic lock_loop_enable_o,
   output logic ref_tick_o,
   output logic [POS_W-1:0] tune_position_o
);
   generate
      if (POS_W < 9 || POS_W > 10)
         $error("POS_W must be 9 or 10");
   endgenerate

   logic wr_stb, rd_stb;
   logic [7:0] addr, wdata, rdata;
   logic [7:0] ctrl_r, prescale_r, divider_r, offset_r, search_r;
   logic [7:0] target_low_r, target_high_r;
   logic [2:0] err_r;
   logic done_r, done_set, flag_a_r, irq_r;
   ftr_cmd_t cmd_r;
   logic [POS_W-1:0] pos_r, goal_r;
   logic [4:0] osc_cnt_r;
   logic [6:0] pre_cnt_r;
   logic [7:0] div_cnt_r;
   logic [12:0] acc_r;
   logic [13:0] acc_sum;
   logic src_tick, pre_tick, power, start;
   logic [POS_W:0] step, next_pos;

   ftr_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_serial (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_n_o(sda_oe_n_o),
      .wr_stb_o(wr_stb),
      .rd_stb_o(rd_stb),
      .addr_o(addr),
      .wdata_o(wdata),
      .rdata_i(rdata)
   );
   assign sda_o = 1'b0;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = wr_stb && (a == off);
   endfunction

   function automatic logic [6:0] pre_mask(input logic [2:0] sel);
      pre_mask = 7'((8'h01 << sel) - 8'h01);
   endfunction

   assign power = ctrl_r[FTR_POWER_BIT];
   assign start = wr_stb && (addr == FTR_ADR_TARGET_HIGH) && power;

   // register writes
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= FTR_RST_RADIO_CONTROL;
         prescale_r <= FTR_RST_PRESCALE;
         divider_r <= FTR_RST_DIVIDER;
         offset_r <= FTR_RST_OFFSET;
         search_r <= FTR_RST_SEARCH;
         target_low_r <= FTR_RST_TARGET;
         target_high_r <= FTR_RST_TARGET;
      end
      else
      begin
         if (hit(addr, FTR_ADR_RADIO_CONTROL))
         begin
            ctrl_r <= wdata;
            // the forbidden source code leaves the old selection in place
            if (wdata[FTR_SRC_LSB+:2] == FTR_SRC_FORBIDDEN)
               ctrl_r[FTR_SRC_LSB+:2] <= ctrl_r[FTR_SRC_LSB+:2];
         end
         if (hit(addr, FTR_ADR_REF_CLOCK_PRESCALE))
            prescale_r <= wdata;
         if (hit(addr, FTR_ADR_REF_CLOCK_DIVIDER))
            divider_r <= wdata;
         if (hit(addr, FTR_ADR_REF_CLOCK_OFFSET))
            offset_r <= wdata;
         if (hit(addr, FTR_ADR_SEARCH_CONTROL))
            search_r <= wdata;
         if (hit(addr, FTR_ADR_TARGET_LOW))
            target_low_r <= wdata;
         if (hit(addr, FTR_ADR_TARGET_HIGH))
            target_high_r <= wdata;
      end
   end

   // reference chain: source, power-of-two prescale, N+1 divide
   assign src_tick = power &&
      ((ctrl_r[FTR_SRC_LSB+:2] == FTR_SRC_OSC_DIV &&
        osc_cnt_r == 5'(FTR_OSC_DIV - 1)) ||
       ctrl_r[FTR_SRC_LSB+:2] == FTR_SRC_DIRECT);
   assign pre_tick = src_tick &&
      ((pre_cnt_r & pre_mask(prescale_r[FTR_PRE_LSB+:3])) ==
       pre_mask(prescale_r[FTR_PRE_LSB+:3]));
   // slope and spread corrections accumulate; a carry stretches one period, except at divider FFh, where the next period shrinks to one prescaled tick
   assign acc_sum = {1'b0, acc_r} +
      {1'b0, prescale_r[FTR_SLOPE_LSB+:5], offset_r};

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         osc_cnt_r <= 5'h00;
         pre_cnt_r <= 7'h00;
         div_cnt_r <= 8'h00;
         acc_r <= 13'h0000;
         ref_tick_o <= 1'b0;
      end
      else
      begin
         ref_tick_o <= 1'b0;
         osc_cnt_r <= osc_cnt_r + 5'h01;
         if (src_tick)
            pre_cnt_r <= pre_cnt_r + 7'h01;
         if (pre_tick)
         begin
            if (div_cnt_r >= divider_r)
            begin
               acc_r <= acc_sum[12:0];
               div_cnt_r <= acc_sum[13] ? 8'hFF : 8'h00;
               ref_tick_o <= !acc_sum[13] || divider_r == 8'hFF;
            end
            else
               div_cnt_r <= div_cnt_r + 8'h01;
         end
      end
   end

   // search step by grid; grid 0 steps by the finest unit
   always_comb
   begin
      case (search_r[FTR_GRID_LSB+:2])
         2'h2: step = (POS_W+1)'(2);
         2'h3: step = (POS_W+1)'(4);
         default: step = (POS_W+1)'(1);
      endcase
      next_pos = {1'b0, pos_r} + step;
   end

   // command engine
   always_ff @(posedge clock_i)
   begin
      done_set <= 1'b0;
      if (rst_i)
      begin
         cmd_r <= FTR_CMD_IDLE;
         err_r <= FTR_ERR_RESET;
         pos_r <= '0;
         goal_r <= '0;
         flag_a_r <= 1'b0;
      end
      else if (!power)
      begin
         flag_a_r <= 1'b0;
         if (cmd_r != FTR_CMD_IDLE)
         begin
            cmd_r <= FTR_CMD_IDLE;
            err_r <= FTR_ERR_FORCED;
            done_set <= 1'b1;
         end
      end
      else if (start)
      begin
         if (cmd_r != FTR_CMD_IDLE)
         begin
            cmd_r <= FTR_CMD_IDLE;
            err_r <= FTR_ERR_FORCED;
            done_set <= 1'b1;
         end
         else
         begin
            goal_r <= POS_W'({wdata, target_low_r});
            err_r <= FTR_ERR_BUSY;
            flag_a_r <= 1'b0;
            cmd_r <= wdata[FTR_SEARCH_SEL_BIT] ? FTR_CMD_SEARCH
                                               : FTR_CMD_TUNE;
         end
      end
      else if (ref_tick_o)
      begin
         case (cmd_r)
            FTR_CMD_TUNE:
               if (pos_r == goal_r)
               begin
                  cmd_r <= FTR_CMD_IDLE;
                  err_r <= FTR_ERR_OK;
                  flag_a_r <= 1'b1;
                  done_set <= 1'b1;
               end
               else if (pos_r < goal_r)
                  pos_r <= pos_r + POS_W'(1);
               else
                  pos_r <= pos_r - POS_W'(1);
            FTR_CMD_SEARCH:
            begin
               // stop when field strength reaches the threshold
               if ({strength_i, strength_plus5_i} >=
                   {search_r[FTR_THR_LSB+:3], search_r[FTR_PLUS5_BIT]})
               begin
                  cmd_r <= FTR_CMD_IDLE;
                  err_r <= FTR_ERR_OK;
                  flag_a_r <= 1'b1;
                  done_set <= 1'b1;
               end
               else if (next_pos[POS_W])
               begin
                  cmd_r <= FTR_CMD_IDLE;
                  err_r <= FTR_ERR_DAC;
                  done_set <= 1'b1;
               end
               else if (next_pos[POS_W-1:0] > goal_r)
               begin
                  cmd_r <= FTR_CMD_IDLE;
                  err_r <= FTR_ERR_BAND;
                  done_set <= 1'b1;
               end
               else
                  pos_r <= next_pos[POS_W-1:0];
            end
            default:
               cmd_r <= FTR_CMD_IDLE;
         endcase
      end
   end

   // done flag: a set in the clearing cycle wins
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         done_r <= 1'b0;
      else if (done_set)
         done_r <= 1'b1;
      else if (rd_stb && addr == FTR_ADR_TUNE_POS_HIGH_STATUS)
         done_r <= 1'b0;
   end

   // irq pin floats in standby so a board pull sets its idle level
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         irq_r <= 1'b0;
         irq_oe_n_o <= 1'b1;
      end
      else
      begin
         irq_r <= (done_r && ctrl_r[FTR_DONE_IE_BIT]) ^
                  ctrl_r[FTR_IRQ_POLARITY_BIT];
         irq_oe_n_o <= !power;
      end
   end
   assign irq_o = irq_r;

   always_comb
   begin
      case (addr)
         FTR_ADR_RADIO_CONTROL: rdata = ctrl_r;
         FTR_ADR_TUNE_POS_LOW: rdata = pos_r[7:0];
         FTR_ADR_TUNE_POS_HIGH_STATUS:
            rdata = {err_r, done_r, flag_a_r, 1'b0,
                     2'(pos_r >> 8)};
         FTR_ADR_REF_CLOCK_PRESCALE: rdata = prescale_r;
         FTR_ADR_REF_CLOCK_DIVIDER: rdata = divider_r;
         FTR_ADR_REF_CLOCK_OFFSET: rdata = offset_r;
         FTR_ADR_SEARCH_CONTROL: rdata = search_r;
         FTR_ADR_TARGET_LOW: rdata = target_low_r;
         FTR_ADR_TARGET_HIGH: rdata = target_high_r;
         default: rdata = 8'h00;
      endcase
   end

   assign radio_power_on_o = power;
   assign lock_loop_enable_o = search_r[FTR_LOCK_BIT];
   assign tune_position_o = pos_r;
endmodule

// *** ftr_tuning_regs_asserts.sv ***
module ftr_tuning_regs_asserts #(
   parameter int POS_W = 10
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // interrupt pin
   input wire logic irq_o,
   input wire logic irq_oe_n_o,
   // receiver side
   input wire logic [2:0] strength_i,
   input wire logic strength_plus5_i,
   input wire logic radio_power_on_o,
   input wire logic lock_loop_enable_o,
   input wire logic ref_tick_o,
   input wire logic [POS_W-1:0] tune_position_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   sequence s_power_off;
      !radio_power_on_o [*2];
   endsequence
   property p_rst_release;
      $fell(rst_i) |-> !radio_power_on_o && !lock_loop_enable_o && !irq_o
         && irq_oe_n_o && sda_oe_n_o && !ref_tick_o && tune_position_o == '0;
   endproperty
   property p_irq_float;
      $stable(radio_power_on_o) |-> irq_oe_n_o == !radio_power_on_o;
   endproperty
   property p_ctrl_on_low;
      $changed({radio_power_on_o, lock_loop_enable_o}) |->
         !scl_i && !$past(scl_i);
   endproperty
   // the slave may only move sda while scl is low
   property p_drive_on_low;
      $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i);
   endproperty
   property p_drive_holds;
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*4];
   endproperty
   property p_pos_step;
      !$past(rst_i) && $changed(tune_position_o) |->
         POS_W'(tune_position_o - $past(tune_position_o))
         inside {POS_W'(1), POS_W'(2), POS_W'(4), {POS_W{1'b1}}};
   endproperty
   property p_pos_tick;
      !$past(rst_i) && $changed(tune_position_o) |->
         ref_tick_o || $past(ref_tick_o) || $past(ref_tick_o, 2);
   endproperty
   property p_pos_off;
      s_power_off |=> $stable(tune_position_o);
   endproperty
   a_rst_release: assert property (p_rst_release)
      else $error("outputs not at reset values after reset");
   a_irq_float: assert property (p_irq_float)
      else $error("irq pin enable does not follow radio power");
   a_ctrl_on_low: assert property (p_ctrl_on_low)
      else $error("control output changed outside a register write");
   a_drive_on_low: assert property (p_drive_on_low)
      else $error("sda drive changed while scl high");
   a_drive_holds: assert property (p_drive_holds)
      else $error("sda drive too short");
   a_pos_step: assert property (p_pos_step)
      else $error("tune position jumped by an illegal step");
   a_pos_tick: assert property (p_pos_tick)
      else $error("tune position moved without a reference tick");
   a_pos_off: assert property (p_pos_off)
      else $error("tune position moved in standby");
endmodule

bind ftr_tuning_regs ftr_tuning_regs_asserts #(.POS_W(POS_W)) i_chk (
   .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o),
   .irq_oe_n_o(irq_oe_n_o), .strength_i(strength_i),
   .strength_plus5_i(strength_plus5_i), .radio_power_on_o(radio_power_on_o),
   .lock_loop_enable_o(lock_loop_enable_o), .ref_tick_o(ref_tick_o),
   .tune_position_o(tune_position_o)
);

// *** ftr_tuning_regs_tb.sv ***
module ftr_tuning_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ftr_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] strength_i = 3'h0;
   logic strength_plus5_i = 1'b0;
   logic scl, host_sda, sda_o, sda_oe_n_o, irq_o, irq_oe_n_o;
   logic radio_power_on_o, lock_loop_enable_o, ref_tick_o;
   logic [9:0] tune_position_o;
   logic [7:0] rv;
   logic ok;
   int g;
   int n_fail = 0;
   int compares = 0;
   logic [7:0] rw_adr [6] = '{FTR_ADR_REF_CLOCK_PRESCALE,
      FTR_ADR_REF_CLOCK_DIVIDER, FTR_ADR_REF_CLOCK_OFFSET,
      FTR_ADR_SEARCH_CONTROL, FTR_ADR_TARGET_LOW, FTR_ADR_TARGET_HIGH};
   logic [7:0] rw_pat [6] = '{8'hA5, 8'h3C, 8'h5A, 8'hCE, 8'h33, 8'h42};
   wire logic sda_w;
   // pull-up wire: low whenever either party pulls it
   assign sda_w = host_sda & (sda_oe_n_o | sda_o);
   always #10 clock_i = ~clock_i;
   ftr_tuning_regs i_dut (
      .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o),
      .irq_oe_n_o(irq_oe_n_o), .strength_i(strength_i),
      .strength_plus5_i(strength_plus5_i),
      .radio_power_on_o(radio_power_on_o),
      .lock_loop_enable_o(lock_loop_enable_o), .ref_tick_o(ref_tick_o),
      .tune_position_o(tune_position_o)
   );
   ftr_host_model i_host (
      .clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda)
   );
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] s);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.wr(a, d, 1, ok);
      chk("write ack", 16'h0001, 16'(ok));
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, rv, ok);
      chk("read ack", 16'h0001, 16'(ok));
      chk($sformatf("register %h", a), 16'(e), 16'(rv));
   endtask
   task automatic wait_pos(input logic [9:0] t);
      for (int i = 0; i < 20000 && tune_position_o !== t; i++)
         @(negedge clock_i);
      repeat (4) @(negedge clock_i);
      chk("tune position", 16'(t), 16'(tune_position_o));
   endtask
   // skips the first tick, whose period may still follow the old setting
   task automatic tick_gap(output int n);
      for (int i = 0; i < 5000 && ref_tick_o !== 1'b1; i++)
         @(negedge clock_i);
      @(negedge clock_i);
      for (n = 1; n < 5000 && ref_tick_o !== 1'b1; n++)
         @(negedge clock_i);
   endtask
   task automatic ref_case(input logic [7:0] c, input logic [7:0] p,
      input logic [7:0] d, input int e);
      wr(FTR_ADR_RADIO_CONTROL, c);
      wr(FTR_ADR_REF_CLOCK_PRESCALE, p);
      wr(FTR_ADR_REF_CLOCK_DIVIDER, d);
      tick_gap(g);
      chk("tick period", 16'(e), 16'(g));
   endtask
   task automatic tally_and_finish();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (90000) @(posedge clock_i);
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      repeat (20) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      rchk(FTR_ADR_RADIO_CONTROL, 8'h00);
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'h20);
      for (int k = 0; k < 6; k++)
      begin
         rchk(rw_adr[k], 8'h00);
         wr(rw_adr[k], rw_pat[k]);
         rchk(rw_adr[k], rw_pat[k]);
      end
      i_host.wr(FTR_ADR_TUNE_POS_LOW, 8'hFF, 1, ok);
      rchk(FTR_ADR_TUNE_POS_LOW, 8'h00);
      i_host.wr(8'h05, 8'hFF, 1, ok);
      rchk(8'h05, 8'h00);
      i_host.dev = 7'h61;
      i_host.wr(FTR_ADR_RADIO_CONTROL, 8'h01, 1, ok);
      chk("foreign address ack", 16'h0000, 16'(ok));
      i_host.dev = FTR_DEV_ADDR;
      i_host.wr(FTR_ADR_REF_CLOCK_OFFSET, 8'h11, 2, ok);
      rchk(FTR_ADR_REF_CLOCK_OFFSET, 8'h11);
      wr(FTR_ADR_REF_CLOCK_OFFSET, 8'h00);
      ref_case(8'h07, 8'h00, 8'h00, 1);
      ref_case(8'h07, 8'h40, 8'h02, 12);
      ref_case(8'h07, 8'hE0, 8'h00, 128);
      ref_case(8'h05, 8'h00, 8'h01, 64);
      ref_case(8'h01, 8'h00, 8'h00, 5000);
      wr(FTR_ADR_RADIO_CONTROL, 8'h03);
      rchk(FTR_ADR_RADIO_CONTROL, 8'h01);
      wr(FTR_ADR_RADIO_CONTROL, 8'h47);
      wr(FTR_ADR_TARGET_LOW, 8'h05);
      wr(FTR_ADR_TARGET_HIGH, 8'h00);
      wait_pos(10'h005);
      chk("irq level", 16'h0001, 16'(irq_o));
      chk("irq enable", 16'h0000, 16'(irq_oe_n_o));
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'h18);
      repeat (4) @(negedge clock_i);
      chk("irq after read", 16'h0000, 16'(irq_o));
      rchk(FTR_ADR_TUNE_POS_LOW, 8'h05);
      wr(FTR_ADR_RADIO_CONTROL, 8'hC7);
      repeat (4) @(negedge clock_i);
      chk("irq inverted", 16'h0001, 16'(irq_o));
      wr(FTR_ADR_RADIO_CONTROL, 8'h47);
      wr(FTR_ADR_REF_CLOCK_PRESCALE, 8'h80);
      wr(FTR_ADR_REF_CLOCK_DIVIDER, 8'h09);
      wr(FTR_ADR_TARGET_LOW, 8'h20);
      wr(FTR_ADR_TARGET_HIGH, 8'h00);
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'hE0);
      wr(FTR_ADR_TARGET_HIGH, 8'h00);
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'hD0);
      wr(FTR_ADR_REF_CLOCK_PRESCALE, 8'h00);
      wr(FTR_ADR_REF_CLOCK_DIVIDER, 8'h00);
      wr(FTR_ADR_TARGET_LOW, 8'h10);
      wr(FTR_ADR_TARGET_HIGH, 8'h00);
      wait_pos(10'h010);
      wr(FTR_ADR_SEARCH_CONTROL, 8'hCF);
      wr(FTR_ADR_TARGET_LOW, 8'h1A);
      wr(FTR_ADR_TARGET_HIGH, 8'h80);
      wait_pos(10'h018);
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'h50);
      wr(FTR_ADR_SEARCH_CONTROL, 8'h4F);
      strength_i = 3'h7;
      for (int k = 0; k < 2; k++)
      begin
         strength_plus5_i = (k == 0);
         wr(FTR_ADR_TARGET_LOW, 8'h30);
         wr(FTR_ADR_TARGET_HIGH, 8'h80);
         repeat (60) @(negedge clock_i);
         i_host.rd(FTR_ADR_TUNE_POS_HIGH_STATUS, rv, ok);
         chk("search", (k == 0) ? 16'h0001 : 16'h0005, 16'(rv[7:4]));
      end
      // walk to one below the top of the range, then let a search run off its end
      wr(FTR_ADR_TARGET_LOW, 8'hFE);
      wr(FTR_ADR_TARGET_HIGH, 8'h03);
      wait_pos(10'h3FE);
      wr(FTR_ADR_TARGET_LOW, 8'hFF);
      wr(FTR_ADR_TARGET_HIGH, 8'h83);
      rchk(FTR_ADR_TUNE_POS_HIGH_STATUS, 8'h73);
      wr(FTR_ADR_TARGET_LOW, 8'h20);
      wr(FTR_ADR_TARGET_HIGH, 8'h00);
      wait_pos(10'h020);
      i_host.rd(FTR_ADR_TUNE_POS_HIGH_STATUS, rv, ok);
      chk("flag_a flag", 16'h0001, 16'(rv[3]));
      wr(FTR_ADR_SEARCH_CONTROL, 8'h6F);
      chk("lock loop", 16'h0001, 16'(lock_loop_enable_o));
      wr(FTR_ADR_RADIO_CONTROL, 8'h06);
      repeat (4) @(negedge clock_i);
      chk("radio power", 16'h0000, 16'(radio_power_on_o));
      chk("irq floating", 16'h0001, 16'(irq_oe_n_o));
      i_host.rd(FTR_ADR_TUNE_POS_HIGH_STATUS, rv, ok);
      chk("flag_a in standby", 16'h0000, 16'(rv[3]));
      tally_and_finish();
   end
endmodule
